// ===== include/modbus_log_regs.svh
// Constants for the serial slave access-log and error handling block
`ifndef MODBUS_LOG_REGS_SVH
`define MODBUS_LOG_REGS_SVH
`define FN_READ_HOLD     8'h03
`define FN_WRITE_MULTI   8'h10
`define FN_ACCESS_LOG    8'h46
`define EXC_FLAG         8'h80
`define EXC_NONE         8'h00
`define EXC_ILLEGAL_FN   8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define EXC_ILLEGAL_DATA 8'h03
`define BROADCAST_ADDR   8'h00
`define MIN_FRAME_LEN    9'd4
`define READ_QUERY_LEN   9'd8
`define LOG_QUERY_LEN    9'd4
`define WRITE_FIXED_LEN  9'd9
`define MAX_REG_COUNT    16'd125
`define RX_BUF_DEPTH     264
`define RX_BUF_LAST      9'd263
`define CRC_INIT         16'hffff
`define CRC_POLY         16'ha001
`define PARITY_NONE      2'd0
`define PARITY_ODD       2'd1
`define PARITY_EVEN      2'd2
`endif

// ===== include/modbus_log_pkg.sv
// Types and the shared CRC function of the serial slave block
package modbus_log_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic       parity;
		logic [1:0] stop;
		logic       overrun;
	} rx_char_s;
	typedef struct packed {
		logic [1:0] parity_mode;
		logic       two_stop;
	} serial_fmt_s;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic        ok;
		logic        bad_value;
		logic [15:0] rdata;
	} reg_rsp_s;
	typedef enum logic [2:0] {ST_RX, ST_CHECK, ST_SCAN_REQ, ST_SCAN_RSP, ST_FINISH, ST_SEND} state_e;

	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction
endpackage

// ===== verilog/modbus_slave_log.sv
// Serial slave: frame checks, exceptions, access log and error counter
`include "modbus_log_regs.svh"
module modbus_slave_log import modbus_log_pkg::*; (
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic [7:0]  SLAVE_ADDR,
	input  wire serial_fmt_s SERIAL_FORMAT_SETTING,
	input  wire logic        RX_VALID,
	input  wire rx_char_s    RX_CHAR,
	input  wire logic        FRAME_END,
	output reg_req_s         REG_REQ,
	input  wire reg_rsp_s    REG_RSP,
	output logic             TX_VALID,
	output logic [7:0]       TX_DATA,
	output logic             TX_LAST,
	input  wire logic        TX_READY,
	output logic [15:0]      COMM_ERROR_COUNTER,
	output logic             COMM_ERROR_ALARM_OUTPUT
);
	state_e      state_reg, state_next;
	logic [7:0]  rx_buf [`RX_BUF_DEPTH];
	logic        rx_we;
	logic [8:0]  rx_len_reg, rx_len_next;
	logic [15:0] rx_crc_reg, rx_crc_next;
	logic        rx_err_reg, rx_err_next;
	logic        bcast_reg, bcast_next;
	logic [7:0]  exc_reg, exc_next;
	logic [6:0]  idx_reg, idx_next;
	logic        any_ok_reg, any_ok_next;
	logic        bad_val_reg, bad_val_next;
	logic [15:0] first_reg, first_next;
	logic [15:0] ok_cnt_reg, ok_cnt_next;
	logic [15:0] log_start_reg, log_start_next;
	logic [15:0] log_count_reg, log_count_next;
	logic [7:0]  hdr_reg [6];
	logic [7:0]  hdr_next [6];
	logic [8:0]  hdr_len_reg, hdr_len_next;
	logic [8:0]  data_len_reg, data_len_next;
	logic [15:0] dbuf [`MAX_REG_COUNT];
	logic        d_we;
	logic [15:0] d_wdata;
	logic [8:0]  tx_idx_reg, tx_idx_next;
	logic [15:0] tx_crc_reg, tx_crc_next;
	logic        tx_valid_reg, tx_valid_next;
	logic [7:0]  tx_data_reg, tx_data_next;
	logic        tx_last_reg, tx_last_next;
	reg_req_s    req_reg, req_next;
	logic [15:0] err_cnt_reg, err_cnt_next;
	logic        alarm_reg, alarm_next;
	logic        err_event, frame_bad, char_bad, par_ok;
	logic [7:0]  fn;
	logic [15:0] q_start, q_cnt;
	logic [8:0]  body_len, nidx, off, wptr;
	logic [15:0] word;

	assign fn      = rx_buf[1];
	assign q_start = {rx_buf[2], rx_buf[3]};
	assign q_cnt   = {rx_buf[4], rx_buf[5]};

	// Per-character checks
	always_comb begin
		case (SERIAL_FORMAT_SETTING.parity_mode)
			`PARITY_ODD:  par_ok = ^{RX_CHAR.data, RX_CHAR.parity};
			`PARITY_EVEN: par_ok = ~^{RX_CHAR.data, RX_CHAR.parity};
			default:      par_ok = 1'b1;
		endcase
		char_bad = !par_ok
			|| !RX_CHAR.stop[0] || (SERIAL_FORMAT_SETTING.two_stop && !RX_CHAR.stop[1])
			|| RX_CHAR.overrun;
	end

	// Short frame, bad residue or flagged characters
	assign frame_bad = rx_err_reg || (rx_len_reg < `MIN_FRAME_LEN)
		|| (rx_crc_reg != 16'h0000);
	// Busy frames are counted when their end is seen outside reception
	assign err_event = (state_reg == ST_CHECK && frame_bad)
		|| (state_reg != ST_RX && state_reg != ST_CHECK && FRAME_END && rx_err_reg);

	always_comb begin
		state_next     = state_reg;
		rx_len_next    = rx_len_reg;
		rx_crc_next    = rx_crc_reg;
		rx_err_next    = rx_err_reg;
		bcast_next     = bcast_reg;
		exc_next       = exc_reg;
		idx_next       = idx_reg;
		any_ok_next    = any_ok_reg;
		bad_val_next   = bad_val_reg;
		first_next     = first_reg;
		ok_cnt_next    = ok_cnt_reg;
		log_start_next = log_start_reg;
		log_count_next = log_count_reg;
		hdr_next       = hdr_reg;
		hdr_len_next   = hdr_len_reg;
		data_len_next  = data_len_reg;
		tx_idx_next    = tx_idx_reg;
		tx_crc_next    = tx_crc_reg;
		tx_valid_next  = tx_valid_reg;
		tx_data_next   = tx_data_reg;
		tx_last_next   = tx_last_reg;
		req_next       = req_reg;
		rx_we          = 1'b0;
		d_we           = 1'b0;
		d_wdata        = 16'h0000;
		body_len       = hdr_len_reg + data_len_reg;
		nidx           = tx_idx_reg + 9'd1;
		off            = nidx - hdr_len_reg;
		word           = dbuf[off[7:1]];
		wptr           = {1'b0, idx_reg, 1'b0} + 9'd7;
		err_cnt_next   = err_cnt_reg + {15'h0000, err_event};
		alarm_next     = alarm_reg | err_event;
		// Characters arriving while busy spoil the frame they belong to
		if (state_reg != ST_RX && RX_VALID)
			rx_err_next = 1'b1;
		if (state_reg != ST_RX && state_reg != ST_CHECK && FRAME_END)
			rx_err_next = RX_VALID;
		case (state_reg)
			ST_RX: begin
				if (RX_VALID) begin
					rx_we = (rx_len_reg != `RX_BUF_LAST);
					rx_len_next = rx_we ? rx_len_reg + 9'd1 : rx_len_reg;
					rx_crc_next = crc16_byte(rx_crc_reg, RX_CHAR.data);
					rx_err_next = rx_err_reg | char_bad | !rx_we;
				end
				if (FRAME_END && (rx_len_reg != 9'd0 || RX_VALID))
					state_next = ST_CHECK;
			end
			ST_CHECK: begin
				rx_len_next  = 9'd0;
				rx_crc_next  = `CRC_INIT;
				rx_err_next  = RX_VALID;
				bcast_next   = (rx_buf[0] == `BROADCAST_ADDR);
				exc_next     = `EXC_NONE;
				idx_next     = 7'd0;
				any_ok_next  = 1'b0;
				bad_val_next = 1'b0;
				ok_cnt_next  = 16'h0000;
				// Dropped frames return straight to reception, no reply
				state_next   = ST_RX;
				if (!frame_bad) begin
					alarm_next = 1'b0;
					if (bcast_next || rx_buf[0] == SLAVE_ADDR) begin
						state_next = ST_FINISH;
						case (fn)
							`FN_READ_HOLD: begin
								if (rx_len_reg != `READ_QUERY_LEN || q_cnt == 16'h0000
									|| q_cnt > `MAX_REG_COUNT)
									exc_next = `EXC_ILLEGAL_DATA;
								else
									state_next = ST_SCAN_REQ;
							end
							`FN_WRITE_MULTI: begin
								if (q_cnt == 16'h0000 || q_cnt > `MAX_REG_COUNT
									|| {1'b0, rx_buf[6]} != {q_cnt[7:0], 1'b0}
									|| rx_len_reg != `WRITE_FIXED_LEN + {1'b0, rx_buf[6]})
									exc_next = `EXC_ILLEGAL_DATA;
								else
									state_next = ST_SCAN_REQ;
							end
							`FN_ACCESS_LOG: begin
								if (rx_len_reg != `LOG_QUERY_LEN)
									exc_next = `EXC_ILLEGAL_DATA;
							end
							default: exc_next = `EXC_ILLEGAL_FN;
						endcase
					end
				end
			end
			ST_SCAN_REQ: begin
				req_next.valid = 1'b1;
				req_next.write = (fn == `FN_WRITE_MULTI);
				req_next.addr  = q_start + {9'h000, idx_reg};
				req_next.wdata = {rx_buf[wptr], rx_buf[wptr + 9'd1]};
				state_next     = ST_SCAN_RSP;
			end
			ST_SCAN_RSP: begin
				req_next.valid = 1'b0;
				if (REG_RSP.ok) begin
					if (!any_ok_reg)
						first_next = req_reg.addr;
					any_ok_next = 1'b1;
					ok_cnt_next = ok_cnt_reg + 16'h0001;
					if (req_reg.write && REG_RSP.bad_value)
						bad_val_next = 1'b1;
				end
				d_we     = !req_reg.write;
				d_wdata  = REG_RSP.ok ? REG_RSP.rdata : 16'h0000;
				idx_next = idx_reg + 7'd1;
				if ({9'h000, idx_next} == q_cnt) begin
					state_next = ST_FINISH;
					if (!any_ok_next)
						exc_next = `EXC_ILLEGAL_ADDR;
					else if (bad_val_next)
						exc_next = `EXC_ILLEGAL_DATA;
				end else begin
					state_next = ST_SCAN_REQ;
				end
			end
			ST_FINISH: begin
				hdr_next[0]   = rx_buf[0];
				hdr_next[1]   = fn;
				data_len_next = 9'd0;
				hdr_len_next  = 9'd6;
				if (exc_reg != `EXC_NONE) begin
					hdr_next[1]  = fn | `EXC_FLAG;
					hdr_next[2]  = exc_reg;
					hdr_len_next = 9'd3;
				end else if (fn == `FN_READ_HOLD) begin
					hdr_next[2]    = {q_cnt[6:0], 1'b0};
					hdr_len_next   = 9'd3;
					data_len_next  = {q_cnt[7:0], 1'b0};
					log_start_next = first_reg;
					log_count_next = ok_cnt_reg;
				end else if (fn == `FN_WRITE_MULTI) begin
					hdr_next[2]    = rx_buf[2];
					hdr_next[3]    = rx_buf[3];
					hdr_next[4]    = rx_buf[4];
					hdr_next[5]    = rx_buf[5];
					log_start_next = first_reg;
					log_count_next = ok_cnt_reg;
				end else begin
					hdr_next[2]    = log_start_reg[15:8];
					hdr_next[3]    = log_start_reg[7:0];
					hdr_next[4]    = log_count_reg[15:8];
					hdr_next[5]    = log_count_reg[7:0];
					log_start_next = 16'h0000;
					log_count_next = 16'h0000;
				end
				if (bcast_reg) begin
					state_next = ST_RX;
				end else begin
					state_next    = ST_SEND;
					tx_idx_next   = 9'd0;
					tx_crc_next   = `CRC_INIT;
					tx_valid_next = 1'b1;
					tx_data_next  = rx_buf[0];
					tx_last_next  = 1'b0;
				end
			end
			ST_SEND: begin
				if (tx_valid_reg && TX_READY) begin
					if (tx_last_reg) begin
						tx_valid_next = 1'b0;
						tx_last_next  = 1'b0;
						state_next    = ST_RX;
					end else begin
						if (tx_idx_reg < body_len)
							tx_crc_next = crc16_byte(tx_crc_reg, tx_data_reg);
						tx_idx_next  = nidx;
						tx_last_next = (nidx == body_len + 9'd1);
						if (nidx < hdr_len_reg)
							tx_data_next = hdr_reg[nidx[2:0]];
						else if (nidx < body_len)
							tx_data_next = off[0] ? word[7:0] : word[15:8];
						else if (nidx == body_len)
							tx_data_next = tx_crc_next[7:0];
						else
							tx_data_next = tx_crc_reg[15:8];
					end
				end
			end
			default: state_next = ST_RX;
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_reg     <= ST_RX;
			rx_len_reg    <= 9'd0;
			rx_crc_reg    <= `CRC_INIT;
			rx_err_reg    <= 1'b0;
			bcast_reg     <= 1'b0;
			exc_reg       <= `EXC_NONE;
			idx_reg       <= 7'd0;
			any_ok_reg    <= 1'b0;
			bad_val_reg   <= 1'b0;
			first_reg     <= 16'h0000;
			ok_cnt_reg    <= 16'h0000;
			log_start_reg <= 16'h0000;
			log_count_reg <= 16'h0000;
			for (int i = 0; i < 6; i++) begin
				hdr_reg[i] <= 8'h00;
			end
			hdr_len_reg   <= 9'd0;
			data_len_reg  <= 9'd0;
			tx_idx_reg    <= 9'd0;
			tx_crc_reg    <= `CRC_INIT;
			tx_valid_reg  <= 1'b0;
			tx_data_reg   <= 8'h00;
			tx_last_reg   <= 1'b0;
			req_reg       <= '0;
			err_cnt_reg   <= 16'h0000;
			alarm_reg     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			rx_len_reg    <= rx_len_next;
			rx_crc_reg    <= rx_crc_next;
			rx_err_reg    <= rx_err_next;
			bcast_reg     <= bcast_next;
			exc_reg       <= exc_next;
			idx_reg       <= idx_next;
			any_ok_reg    <= any_ok_next;
			bad_val_reg   <= bad_val_next;
			first_reg     <= first_next;
			ok_cnt_reg    <= ok_cnt_next;
			log_start_reg <= log_start_next;
			log_count_reg <= log_count_next;
			hdr_reg       <= hdr_next;
			hdr_len_reg   <= hdr_len_next;
			data_len_reg  <= data_len_next;
			tx_idx_reg    <= tx_idx_next;
			tx_crc_reg    <= tx_crc_next;
			tx_valid_reg  <= tx_valid_next;
			tx_data_reg   <= tx_data_next;
			tx_last_reg   <= tx_last_next;
			req_reg       <= req_next;
			err_cnt_reg   <= err_cnt_next;
			alarm_reg     <= alarm_next;
		end
	end

	// Frame and read-data memories
	always_ff @(posedge REF_CLK) begin
		if (rx_we)
			rx_buf[rx_len_reg] <= RX_CHAR.data;
		if (d_we)
			dbuf[idx_reg] <= d_wdata;
	end

	assign REG_REQ                 = req_reg;
	assign TX_VALID                = tx_valid_reg;
	assign TX_DATA                 = tx_data_reg;
	assign TX_LAST                 = tx_last_reg;
	assign COMM_ERROR_COUNTER      = err_cnt_reg;
	assign COMM_ERROR_ALARM_OUTPUT = alarm_reg;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	sequence drop_seq;
		state_reg == ST_CHECK && frame_bad;
	endsequence
	sequence reply_start_seq;
		state_reg == ST_FINISH && !bcast_reg;
	endsequence

	err_count_a: assert property (err_event |=> err_cnt_reg == $past(err_cnt_reg) + 16'h0001)
		else $error("error counter did not step by one");
	err_alarm_a: assert property (err_event |=> COMM_ERROR_ALARM_OUTPUT)
		else $error("alarm not raised on reception error");
	drop_silent_a: assert property (drop_seq |=> state_reg == ST_RX && !TX_VALID)
		else $error("bad frame not dropped silently");
	bcast_silent_a: assert property (state_reg == ST_FINISH && bcast_reg |=> !TX_VALID [*2])
		else $error("reply sent to broadcast");
	reply_addr_a: assert property (reply_start_seq |=> TX_VALID && TX_DATA == $past(rx_buf[0]))
		else $error("reply does not echo slave address");
	exc_func_a: assert property (state_reg == ST_FINISH && exc_reg != `EXC_NONE
		|=> hdr_reg[1] == ($past(fn) | `EXC_FLAG) && hdr_reg[2] == $past(exc_reg))
		else $error("exception header wrong");
	bad_func_a: assert property (state_reg == ST_CHECK && !frame_bad && fn != `FN_READ_HOLD
		&& fn != `FN_WRITE_MULTI && fn != `FN_ACCESS_LOG
		&& (bcast_next || rx_buf[0] == SLAVE_ADDR) |=> exc_reg == `EXC_ILLEGAL_FN)
		else $error("unsupported function not code 01");
	none_ok_a: assert property (state_reg == ST_FINISH && exc_reg != `EXC_ILLEGAL_DATA
		&& (fn == `FN_READ_HOLD || fn == `FN_WRITE_MULTI)
		|-> (exc_reg == `EXC_ILLEGAL_ADDR) == !any_ok_reg)
		else $error("address exception does not match access outcome");
	log_keep_a: assert property (state_reg == ST_FINISH && exc_reg != `EXC_NONE
		|=> $stable(log_start_reg) && $stable(log_count_reg))
		else $error("log changed on exception");
endmodule // modbus_slave_log

// ===== verification/modbus_master_model.sv
// Serial master model: sends query frames and collects the slave replies
`include "modbus_log_regs.svh"
module modbus_master_model import modbus_log_pkg::*; (
	input  wire logic        REF_CLK,
	input  wire serial_fmt_s SERIAL_FORMAT_SETTING,
	output logic             RX_VALID,
	output rx_char_s         RX_CHAR,
	output logic             FRAME_END,
	input  wire logic        TX_VALID,
	input  wire logic [7:0]  TX_DATA,
	input  wire logic        TX_LAST,
	output logic             TX_READY
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic       done;
	logic       slow;
	initial begin
		RX_VALID = 1'b0;
		RX_CHAR = '0;
		FRAME_END = 1'b0;
		TX_READY = 1'b1;
		done = 1'b0;
		slow = 1'b0;
	end
	function automatic logic [15:0] calc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction
	// Kind: 0 good, 1 parity, 2 stop bits, 3 overrun, 4 bad check, 5 no check bytes
	task automatic send(input logic [7:0] q[$], input int kind);
		logic [15:0] c;
		c = calc(q) ^ ((kind == 4) ? 16'h0001 : 16'h0000);
		if (kind != 5) begin
			q.push_back(c[7:0]);
			q.push_back(c[15:8]);
		end
		got.delete();
		done = 1'b0;
		foreach (q[i]) begin
			@(posedge REF_CLK);
			#1;
			RX_VALID = 1'b1;
			RX_CHAR.data = q[i];
			RX_CHAR.parity = (SERIAL_FORMAT_SETTING.parity_mode == `PARITY_ODD) ? ~^q[i] : ^q[i];
			RX_CHAR.stop = (i == 1 && kind == 2) ? 2'b00 : 2'b11;
			RX_CHAR.overrun = (i == 1 && kind == 3);
			if (i == 1 && kind == 1) RX_CHAR.parity = ~RX_CHAR.parity;
		end
		@(posedge REF_CLK);
		#1;
		RX_VALID = 1'b0;
		RX_CHAR.data = ~RX_CHAR.data;
		FRAME_END = 1'b1;
		@(posedge REF_CLK);
		#1;
		FRAME_END = 1'b0;
	endtask
	// Slow mode stalls every other cycle
	always @(posedge REF_CLK) TX_READY <= #1 (slow ? ~TX_READY : 1'b1);
	always @(posedge REF_CLK) begin
		if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
			got.push_back(TX_DATA);
			if (TX_LAST === 1'b1) done = 1'b1;
		end
	end
endmodule // modbus_master_model

// ===== verification/tb.sv
// Testbench for the serial slave access-log and error block
module tb import modbus_log_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk;
	logic        reset;
	serial_fmt_s fmt;
	logic        rx_valid;
	rx_char_s    rx_char;
	logic        frame_end;
	reg_req_s    req;
	reg_rsp_s    rsp;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_last;
	logic        tx_ready;
	logic [15:0] err_count;
	logic        alarm;
	int          failures = 0;
	int          checks = 0;
	modbus_slave_log u_modbus_slave_log (
		.REF_CLK(ref_clk), .RESET(reset), .SLAVE_ADDR(8'h19),
		.SERIAL_FORMAT_SETTING(fmt), .RX_VALID(rx_valid), .RX_CHAR(rx_char),
		.FRAME_END(frame_end), .REG_REQ(req), .REG_RSP(rsp), .TX_VALID(tx_valid),
		.TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready),
		.COMM_ERROR_COUNTER(err_count), .COMM_ERROR_ALARM_OUTPUT(alarm));
	modbus_master_model u_model (
		.REF_CLK(ref_clk), .SERIAL_FORMAT_SETTING(fmt), .RX_VALID(rx_valid),
		.RX_CHAR(rx_char), .FRAME_END(frame_end), .TX_VALID(tx_valid),
		.TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready));
	// Register map: 16 registers, value ffff refused
	always_comb begin
		rsp.ok = (req.addr < 16'h0010);
		rsp.bad_value = req.write && (req.wdata == 16'hffff);
		rsp.rdata = req.addr ^ 16'h5a00;
	end
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic reply(input logic [7:0] q[$]);
		logic [15:0] c;
		int n;
		c = u_model.calc(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		n = 0;
		while (u_model.done !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		if (n >= 300) begin
			failures++;
			$display("MISMATCH reply_wait expected done seen timeout");
			summarize();
		end
		chk("reply_len", 16'(q.size()), 16'(u_model.got.size()));
		foreach (q[i]) if (i < u_model.got.size()) chk("reply_byte", {8'h00, q[i]}, {8'h00, u_model.got[i]});
	endtask
	task automatic silent();
		repeat (60) @(posedge ref_clk);
		chk("no_reply", 16'h0000, 16'(u_model.got.size()));
	endtask
	task automatic t_log();
		u_model.send('{8'h19, 8'h10, 8'h00, 8'h0e, 8'h00, 8'h03, 8'h06,
			8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc}, 0);
		reply('{8'h19, 8'h10, 8'h00, 8'h0e, 8'h00, 8'h03});
		u_model.send('{8'h19, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 0);
		reply('{8'h19, 8'h85, 8'h01});
		u_model.send('{8'h19, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, 0);
		reply('{8'h19, 8'h83, 8'h02});
		u_model.send('{8'h19, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'hff, 8'hff}, 0);
		reply('{8'h19, 8'h90, 8'h03});
		u_model.send('{8'h19, 8'h46}, 0);
		reply('{8'h19, 8'h46, 8'h00, 8'h0e, 8'h00, 8'h02});
		u_model.send('{8'h19, 8'h46}, 0);
		reply('{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
		$display("test log done");
	endtask
	task automatic t_read();
		u_model.slow = 1'b1;
		u_model.send('{8'h19, 8'h03, 8'h00, 8'h0f, 8'h00, 8'h02}, 0);
		reply('{8'h19, 8'h03, 8'h04, 8'h5a, 8'h0f, 8'h00, 8'h00});
		u_model.slow = 1'b0;
		$display("test read done");
	endtask
	task automatic t_bcast();
		u_model.send('{8'h00, 8'h46}, 0);
		silent();
		u_model.send('{8'h00, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'h11, 8'h22}, 0);
		silent();
		u_model.send('{8'h19, 8'h46}, 0);
		reply('{8'h19, 8'h46, 8'h00, 8'h02, 8'h00, 8'h01});
		$display("test broadcast done");
	endtask
	task automatic t_err();
		logic [15:0] base;
		base = err_count;
		for (int k = 1; k <= 5; k++) begin
			if (k == 5) u_model.send('{8'h19, 8'h46, 8'h8b}, k);
			else u_model.send('{8'h19, 8'h46}, k);
			silent();
			chk("err_count", base + 16'(k), err_count);
			chk("alarm", 16'h0001, {15'h0000, alarm});
		end
		u_model.send('{8'h19, 8'h46}, 0);
		reply('{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
		chk("alarm_clear", 16'h0000, {15'h0000, alarm});
		$display("test errors done");
	endtask
	task automatic t_fmt();
		logic [15:0] base;
		fmt = '{parity_mode: 2'h1, two_stop: 1'b1};
		base = err_count;
		u_model.send('{8'h19, 8'h46}, 0);
		reply('{8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
		u_model.send('{8'h19, 8'h46}, 1);
		silent();
		chk("err_count_odd", base + 16'h0001, err_count);
		u_model.send('{8'h22, 8'h46}, 0);
		silent();
		chk("err_count_addr", base + 16'h0001, err_count);
		// Second query lands while the first reply is still going out
		u_model.send('{8'h19, 8'h46}, 0);
		u_model.send('{8'h19, 8'h46}, 0);
		repeat (60) @(posedge ref_clk);
		chk("err_count_busy", base + 16'h0002, err_count);
		chk("alarm_busy", 16'h0001, {15'h0000, alarm});
		fmt = '{parity_mode: 2'h2, two_stop: 1'b0};
		$display("test format done");
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		reset = 1'b1;
		fmt = '{parity_mode: 2'h2, two_stop: 1'b0};
		repeat (2) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_log();
		t_read();
		t_bcast();
		t_err();
		t_fmt();
		summarize();
	end
endmodule // tb
